/* File: hw/tsq_core.sv */
// Behaviour
// [RULE1] Mode 11: level detect, no step delay; mode 10: level detect, delay.
// [RULE2] Mode 01: edge detect, no step delay; mode 00: edge detect, delay.
// [RULE3] Trigger mode affects only the wait-high and wait-low commands.
// [RULE4] Timer-zero limit, 16 bits, zero at reset, used by its command.
// [RULE5] Timer-one limit, 16 bits, zero at reset, used by its command.
// [RULE6] Limits are read-only while enable and start are both one.
// [RULE7] Software keeps single-step mode for debugging tools only.
// [RULE8] Writes while read-only are ignored; old values stay readable.
module tsq_core
  import tsq_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic        trig_in,
  output logic             cmd_done,
  output logic             step_delay_req,
  output logic      [15:0] timer_limit,
  output logic             timer_limit_valid
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic        enable;
    logic        start;
    logic [1:0]  mode;
    logic [15:0] t0_limit;
    logic [15:0] t1_limit;
    logic [15:0] rdata;
    logic        done;
    logic        delay;
    logic [15:0] tlim;
    logic        tvalid;
  } tsq_state_type;

  tsq_state_type state;
  tsq_state_type next_state;
  logic          locked;
  logic          is_wait;
  logic          hit;
  tsq_mode_type  md;

  assign locked  = state.enable && state.start; // RULE6
  assign is_wait = cmd_valid && (cmd_code == TSQ_CMD_WAIT_HIGH ||
                                 cmd_code == TSQ_CMD_WAIT_LOW);
  assign md      = tsq_decode_mode(state.mode);

  tsq_trig_detect u_det (
    .core_clk     (core_clk),
    .reset        (reset),
    .arm          (is_wait && locked),
    .want_high    (cmd_code == TSQ_CMD_WAIT_HIGH),
    .level_detect (md.level_detect),
    .trig_in      (trig_in),
    .hit          (hit)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state        = state;
    next_state.rdata  = '0;
    next_state.done   = 1'b0;
    next_state.delay  = 1'b0;
    next_state.tvalid = 1'b0;
    if (wr) begin
      unique case (addr)
        TSQ_ADDR_CONTROL: begin
          next_state.enable = wdata[TSQ_CTL_ENABLE_BIT];
          next_state.start  = wdata[TSQ_CTL_START_BIT];
          next_state.mode   = wdata[TSQ_CTL_MODE_LSB +: 2];
        end
        TSQ_ADDR_T0_LIMIT: begin
          if (!locked) begin // RULE6 RULE8
            next_state.t0_limit = wdata;
          end
        end
        TSQ_ADDR_T1_LIMIT: begin
          if (!locked) begin // RULE6 RULE8
            next_state.t1_limit = wdata;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      unique case (addr)
        TSQ_ADDR_CONTROL: begin
          next_state.rdata[TSQ_CTL_ENABLE_BIT] = state.enable;
          next_state.rdata[TSQ_CTL_START_BIT]  = state.start;
          next_state.rdata[TSQ_CTL_MODE_LSB +: 2] = state.mode;
        end
        TSQ_ADDR_T0_LIMIT: next_state.rdata = state.t0_limit; // RULE8
        TSQ_ADDR_T1_LIMIT: next_state.rdata = state.t1_limit; // RULE8
        TSQ_ADDR_STATUS:   next_state.rdata = {15'h0000, locked};
        default:           next_state.rdata = '0;
      endcase
    end
    // Wait commands finish on trigger; mode picks the exit delay
    if (hit) begin
      next_state.done  = 1'b1;
      next_state.delay = !md.skip_delay; // RULE1 RULE2 RULE3
    end
    // Timer commands hand their limit to the timer; delay as normal
    if (cmd_valid && locked && cmd_code == TSQ_CMD_TIMER0) begin
      next_state.tlim   = state.t0_limit; // RULE4
      next_state.tvalid = 1'b1;
      next_state.done   = 1'b1;
      next_state.delay  = 1'b1; // RULE3
    end
    if (cmd_valid && locked && cmd_code == TSQ_CMD_TIMER1) begin
      next_state.tlim   = state.t1_limit; // RULE5
      next_state.tvalid = 1'b1;
      next_state.done   = 1'b1;
      next_state.delay  = 1'b1; // RULE3
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state          <= '0;
      state.mode     <= TSQ_MODE_RESET;
      state.t0_limit <= TSQ_LIMIT_RESET; // RULE4
      state.t1_limit <= TSQ_LIMIT_RESET; // RULE5
    end else begin
      state <= next_state;
    end
  end

  assign rdata             = state.rdata;
  assign cmd_done          = state.done;
  assign step_delay_req    = state.delay;
  assign timer_limit       = state.tlim;
  assign timer_limit_valid = state.tvalid;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_t0_cmd;
    cmd_valid && locked && cmd_code == TSQ_CMD_TIMER0;
  endsequence
  sequence s_t1_cmd;
    cmd_valid && locked && cmd_code == TSQ_CMD_TIMER1;
  endsequence
  // Wanted level present while a wait command runs in level mode
  sequence s_wait_level_hit;
    is_wait && locked && md.level_detect &&
      trig_in == (cmd_code == TSQ_CMD_WAIT_HIGH);
  endsequence
  // Wanted level present but unchanged while in edge mode
  sequence s_wait_edge_flat;
    is_wait && locked && !md.level_detect &&
      trig_in == (cmd_code == TSQ_CMD_WAIT_HIGH) &&
      trig_in == $past(trig_in);
  endsequence

  a_limit_zero_hold: assert property ( // RULE6
    @(posedge core_clk) disable iff (reset)
    (wr && addr == TSQ_ADDR_T0_LIMIT && locked) |=>
      state.t0_limit == $past(state.t0_limit))
    else $error("timer zero limit changed while locked");
  a_limit_one_hold: assert property ( // RULE8
    @(posedge core_clk) disable iff (reset)
    (wr && addr == TSQ_ADDR_T1_LIMIT && locked) |=>
      state.t1_limit == $past(state.t1_limit))
    else $error("timer one limit changed while locked");
  a_limit_zero_write: assert property ( // RULE4
    @(posedge core_clk) disable iff (reset)
    (wr && addr == TSQ_ADDR_T0_LIMIT && !locked) |=>
      state.t0_limit == $past(wdata))
    else $error("timer zero limit write lost");
  a_limit_one_write: assert property ( // RULE5
    @(posedge core_clk) disable iff (reset)
    (wr && addr == TSQ_ADDR_T1_LIMIT && !locked) |=>
      state.t1_limit == $past(wdata))
    else $error("timer one limit write lost");
  a_skip_delay_mode: assert property ( // RULE1
    @(posedge core_clk) disable iff (reset)
    (hit && md.skip_delay) |=> cmd_done && !step_delay_req)
    else $error("delay issued in skip mode");
  a_keep_delay_mode: assert property ( // RULE2
    @(posedge core_clk) disable iff (reset)
    (hit && !md.skip_delay) |=> cmd_done && step_delay_req)
    else $error("delay missing in delay mode");
  a_level_hit_done: assert property ( // RULE1
    @(posedge core_clk) disable iff (reset)
    s_wait_level_hit |=> cmd_done)
    else $error("level trigger not taken");
  a_edge_needs_change: assert property ( // RULE2
    @(posedge core_clk) disable iff (reset)
    s_wait_edge_flat |=> !cmd_done)
    else $error("edge mode fired on a steady level");
  a_timer_delay_fixed: assert property ( // RULE3
    @(posedge core_clk) disable iff (reset)
    timer_limit_valid |-> step_delay_req)
    else $error("timer command lost its delay");
  a_timer_zero_pass: assert property ( // RULE4
    @(posedge core_clk) disable iff (reset)
    s_t0_cmd |=> timer_limit_valid &&
      timer_limit == $past(state.t0_limit))
    else $error("timer zero limit not handed on");
  a_timer_one_pass: assert property ( // RULE5
    @(posedge core_clk) disable iff (reset)
    s_t1_cmd |=> timer_limit_valid &&
      timer_limit == $past(state.t1_limit))
    else $error("timer one limit not handed on");
  a_idle_no_done: assert property ( // RULE6
    @(posedge core_clk) disable iff (reset)
    !locked |=> !cmd_done && !timer_limit_valid)
    else $error("command ran while not executing");
  a_status_locked: assert property ( // RULE6
    @(posedge core_clk) disable iff (reset)
    (rd && addr == TSQ_ADDR_STATUS) |=>
      rdata == {15'h0000, $past(locked)})
    else $error("status does not show the lock");
  a_readback_limit: assert property ( // RULE8
    @(posedge core_clk) disable iff (reset)
    (rd && addr == TSQ_ADDR_T1_LIMIT) |=>
      rdata == $past(state.t1_limit))
    else $error("timer one limit readback wrong");

endmodule : tsq_core

/* File: hw/tsq_pkg.sv */
package tsq_pkg;

  // ****************************************************************
  // Register map (word addresses on the plain register port)
  // ****************************************************************
  localparam logic [3:0]  TSQ_ADDR_CONTROL  = 4'h0;
  localparam logic [3:0]  TSQ_ADDR_T0_LIMIT = 4'h1;
  localparam logic [3:0]  TSQ_ADDR_T1_LIMIT = 4'h2;
  localparam logic [3:0]  TSQ_ADDR_STATUS   = 4'h3;

  // Control register fields
  localparam int          TSQ_CTL_ENABLE_BIT = 15;
  localparam int          TSQ_CTL_START_BIT  = 7;
  localparam int          TSQ_CTL_MODE_LSB   = 0;

  localparam logic [15:0] TSQ_LIMIT_RESET   = 16'h0000;
  localparam logic [1:0]  TSQ_MODE_RESET    = 2'h0;

  // ****************************************************************
  // Step command codes
  // ****************************************************************
  localparam logic [3:0]  TSQ_CMD_WAIT_HIGH = 4'h4;
  localparam logic [3:0]  TSQ_CMD_WAIT_LOW  = 4'h5;
  localparam logic [3:0]  TSQ_CMD_TIMER0    = 4'h6;
  localparam logic [3:0]  TSQ_CMD_TIMER1    = 4'h7;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tsq_bus_req_type;

  typedef struct packed {
    logic        level_detect;
    logic        skip_delay;
  } tsq_mode_type;

  function automatic tsq_mode_type tsq_decode_mode(input logic [1:0] m);
    tsq_mode_type r;
    r.level_detect = m[1];
    r.skip_delay   = m[0];
    return r;
  endfunction : tsq_decode_mode

endpackage : tsq_pkg

/* File: hw/tsq_trig_detect.sv */
module tsq_trig_detect
  import tsq_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic arm,
  input  wire logic want_high,
  input  wire logic level_detect,
  input  wire logic trig_in,
  output logic      hit
);

  typedef struct packed {
    logic prev;
  } tsq_det_state_type;

  tsq_det_state_type state;
  tsq_det_state_type next_state;
  logic              lvl;

  always_comb begin
    next_state      = state;
    next_state.prev = trig_in;
    lvl             = (trig_in == want_high);
    if (level_detect) begin
      hit = arm && lvl;
    end else begin
      // Edge mode needs a transition into the wanted level
      hit = arm && lvl && (state.prev != trig_in);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule : tsq_trig_detect

/* File: verification/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tsq_pkg::*;

  // ****************************************************************
  // Clock, reset and design under test
  // ****************************************************************
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic [3:0]  addr     = 4'h0;
  logic [15:0] wdata    = 16'h0000;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [15:0] rdata;
  logic        cmd_valid = 1'b0;
  logic [3:0]  cmd_code  = 4'h0;
  logic        trig_in   = 1'b0;
  logic        cmd_done, step_delay_req, timer_limit_valid;
  logic [15:0] timer_limit;
  logic        seen, sdr, tlv;
  logic [15:0] tl, r;
  int          n_errors  = 0;
  int          cmp_count = 0;

  always #2.5 core_clk = ~core_clk;

  tsq_core tsq_core_inst (
    .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .trig_in(trig_in), .cmd_done(cmd_done),
    .step_delay_req(step_delay_req), .timer_limit(timer_limit),
    .timer_limit_valid(timer_limit_valid)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    // Read data stand only in the cycle after the strobe
    @(negedge core_clk);
    r = rdata;
  endtask : rd_reg

  task automatic cmd_on(input logic [3:0] c);
    @(posedge core_clk);
    cmd_code  <= c;
    cmd_valid <= 1'b1;
  endtask : cmd_on

  // Dropping valid one edge late may restart a command; idle cycles absorb it
  task automatic cmd_off;
    @(posedge core_clk) cmd_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : cmd_off

  // Clears the captures first so a missed pulse cannot reuse old values
  task automatic wait_done(input int lim);
    seen = 1'b0;
    sdr  = 1'b0;
    tlv  = 1'b0;
    tl   = 16'h0000;
    repeat (lim) begin
      @(negedge core_clk);
      if (cmd_done === 1'b1) begin
        seen = 1'b1;
        sdr  = step_delay_req;
        tl   = timer_limit;
        tlv  = timer_limit_valid;
        break;
      end
    end
  endtask : wait_done

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset_and_write;
    rd_reg(TSQ_ADDR_T0_LIMIT);
    check("t0_reset", r, 16'h0000);
    rd_reg(TSQ_ADDR_T1_LIMIT);
    check("t1_reset", r, 16'h0000);
    rd_reg(4'hF);
    check("unmapped", r, 16'h0000);
    wr_reg(TSQ_ADDR_CONTROL, 16'h8000);
    // Enable without start must not run a command
    cmd_on(TSQ_CMD_TIMER0);
    wait_done(4);
    check("idle_cmd", {15'h0, seen}, 16'h0000);
    cmd_off;
    wr_reg(TSQ_ADDR_T0_LIMIT, 16'hA5C3);
    wr_reg(TSQ_ADDR_T1_LIMIT, 16'h5A3C);
    rd_reg(TSQ_ADDR_T0_LIMIT);
    check("t0_write", r, 16'hA5C3);
    rd_reg(TSQ_ADDR_T1_LIMIT);
    check("t1_write", r, 16'h5A3C);
  endtask : test_reset_and_write

  task automatic test_locked;
    // Control words carry no single-step selection
    wr_reg(TSQ_ADDR_CONTROL, 16'h8080);
    rd_reg(TSQ_ADDR_CONTROL);
    check("control", r, 16'h8080);
    rd_reg(TSQ_ADDR_STATUS);
    check("locked", r, 16'h0001);
    wr_reg(TSQ_ADDR_T0_LIMIT, 16'hFFFF);
    wr_reg(TSQ_ADDR_T1_LIMIT, 16'h0001);
    rd_reg(TSQ_ADDR_T0_LIMIT);
    check("t0_held", r, 16'hA5C3);
    rd_reg(TSQ_ADDR_T1_LIMIT);
    check("t1_held", r, 16'h5A3C);
  endtask : test_locked

  task automatic test_timers;
    for (int m = 0; m < 4; m += 3) begin
      wr_reg(TSQ_ADDR_CONTROL, 16'h8080 | 16'(m));
      cmd_on(TSQ_CMD_TIMER0);
      wait_done(4);
      check("t0_done", {15'h0, seen}, 16'h0001);
      check("t0_delay", {15'h0, sdr}, 16'h0001);
      check("t0_valid", {15'h0, tlv}, 16'h0001);
      check("t0_limit", tl, 16'hA5C3);
      cmd_off;
      cmd_on(TSQ_CMD_TIMER1);
      wait_done(4);
      check("t1_done", {15'h0, seen}, 16'h0001);
      check("t1_delay", {15'h0, sdr}, 16'h0001);
      check("t1_valid", {15'h0, tlv}, 16'h0001);
      check("t1_limit", tl, 16'h5A3C);
      cmd_off;
    end
  endtask : test_timers

  task automatic test_wait_modes;
    logic w;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        w = (k == 0);
        wr_reg(TSQ_ADDR_CONTROL, 16'h8080 | 16'(m));
        @(posedge core_clk) trig_in <= w;
        @(posedge core_clk);
        cmd_on(w ? TSQ_CMD_WAIT_HIGH : TSQ_CMD_WAIT_LOW);
        wait_done(4);
        if (m < 2) begin
          // A level already present is no edge
          check("edge_early", {15'h0, seen}, 16'h0000);
          @(posedge core_clk) trig_in <= ~w;
          @(posedge core_clk) trig_in <= w;
          wait_done(6);
        end
        check("wait_done", {15'h0, seen}, 16'h0001);
        check("delay_req", {15'h0, sdr}, {15'h0, ~m[0]});
        cmd_off;
      end
    end
  endtask : test_wait_modes

  // ****************************************************************
  // Verdict and main sequence
  // ****************************************************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    test_reset_and_write();
    test_locked();
    test_timers();
    test_wait_modes();
    print_verdict();
  end

  initial begin
    #50000;
    n_errors++;
    print_verdict();
  end
endmodule : tb_top
